// file: core/uhp_host_port.sv
// host bus front end of a fifo uart: pc decode and standalone personalities
// Summary of operation
// RULE1: pc personality uses pin 16 as address line 7 in port decode
// RULE2: standalone personality uses pin 16 as active-low chip select
// RULE3: standalone drives the baud pin with the 16x baud clock
// RULE4: pc personality routes the internal baud clock to the receiver clock
// RULE5: pc personality drives baud pin low when address hits first printer port
// RULE6: active-low write strobe captures host data into the addressed register
// RULE7: pc personality uses pin 21 as address line 8 in port decode
// RULE8: standalone pin 21 is an active-high write strobe, either strobe writes
// RULE9: active-low read strobe drives addressed register onto host data bus
// RULE10: pc personality uses pin 25 as address line 3 in port decode
// RULE11: standalone pin 25 is an active-high read strobe, either strobe reads
// RULE12: standalone drive-disable goes low for the whole host read
// RULE13: pc personality drive-disable pin decodes second printer port, active low
// RULE14: pin 27 is three-state irq in pc, tx fifo full in standalone
// RULE15: pin 32 is three-state irq in pc, low on rx fifo full standalone
// RULE16: pc port decode is valid only while address enable is low
// RULE17: standalone latches chip selects and a2-a0 while address strobe is low
// RULE18: host holds address strobe low when no latching is wanted
// RULE19: three low address lines select the accessed internal register
// RULE20: port select a helps choose one of four serial port addresses
// RULE21: personality select low means pc, high or open means standalone
// RULE22: standalone selected only with both high selects high and low select low
// RULE23: port selects b and c with a choose the serial port address
// RULE24: pc personality uses remaining pins as address lines 4, 5, 6 and 9
// RULE25: port select to base address map is a build-time parameter
`timescale 1ns/10ps
module uhp_host_port #(
  parameter uhp_pkg::uhp_port_t [7:0] PORT_MAP = uhp_pkg::COM_MAP_DEF
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  // host pins
  input  wire logic [7:0]                    pin_data_in,
  output logic      [7:0]                    pin_data_out,
  output logic                               pin_data_oe,
  input  wire logic [2:0]                    addr_low,
  input  wire logic                          addr3_or_read_strobe_high,
  input  wire logic                          addr4,
  input  wire logic                          addr5_or_select_high_a,
  input  wire logic                          addr6_or_select_high_b,
  input  wire logic                          addr7_or_select_low,
  input  wire logic                          addr8_or_write_strobe_high,
  input  wire logic                          addr9,
  input  wire logic                          write_strobe_low,
  input  wire logic                          read_strobe_low,
  input  wire logic                          addr_enable_or_addr_latch_low,
  input  wire logic                          port_select_a,
  input  wire logic                          port_select_b_or_rx_clk,
  input  wire logic                          port_select_c,
  input  wire logic                          personality_sel,
  output logic                               baud_clk_or_printer1_decode,
  output logic                               drive_disable_or_printer2_decode,
  output logic                               irq_c_or_tx_fifo_full,
  output logic                               irq_c_or_tx_fifo_full_oe,
  output logic                               irq_b_or_rx_fifo_full_low,
  output logic                               irq_b_or_rx_fifo_full_low_oe,
  // uart core side
  input  wire logic [uhp_pkg::BAUD_DIV_W-1:0] baud_divisor,
  input  wire logic                          irq_b,
  input  wire logic                          irq_c,
  input  wire logic                          irq_drive_en,
  input  wire logic                          tx_fifo_full,
  input  wire logic                          rx_fifo_full,
  input  wire logic [7:0]                    reg_rdata,
  output logic      [2:0]                    reg_addr,
  output logic      [7:0]                    reg_wdata,
  output logic                               reg_wr,
  output logic                               reg_rd,
  output logic                               rx_clk,
  output logic                               pc_decode_personality
);

  // ==========================================================
  // pin resynchronisation
  uhp_pin_if pins ();

  assign pins.raw = {port_select_b_or_rx_clk, port_select_c, port_select_b_or_rx_clk,
                     port_select_a, addr_enable_or_addr_latch_low, read_strobe_low,
                     write_strobe_low, personality_sel, addr9, addr8_or_write_strobe_high,
                     addr7_or_select_low, addr6_or_select_high_b, addr5_or_select_high_a,
                     addr4, addr3_or_read_strobe_high, addr_low, pin_data_in};

  uhp_sync u_sync (
    .clk  (clk),
    .rst  (rst),
    .pins (pins.sampler)
  );

  // ==========================================================
  // personality and address assembly
  logic                       pc;
  logic [uhp_pkg::ADDR_W-1:0] host_addr;
  logic [7:0]                 bus_s;
  logic                       aen_low_s;
  logic [uhp_pkg::SEL_W-1:0]  port_idx;
  uhp_pkg::uhp_port_t         port_entry;

  // open pin is pulled up outside, so a floating select reads standalone
  assign pc = ~pins.sync[uhp_pkg::P_SEL]; // RULE21

  assign host_addr = {pins.sync[uhp_pkg::P_A9], // RULE24
                      pins.sync[uhp_pkg::P_A8], // RULE7
                      pins.sync[uhp_pkg::P_A7], // RULE1
                      pins.sync[uhp_pkg::P_A6], // RULE24
                      pins.sync[uhp_pkg::P_A5], // RULE24
                      pins.sync[uhp_pkg::P_A4], // RULE24
                      pins.sync[uhp_pkg::P_A3], // RULE10
                      pins.sync[uhp_pkg::P_A0 +: 3]};

  assign bus_s     = pins.sync[uhp_pkg::P_DATA +: 8];
  assign aen_low_s = pins.sync[uhp_pkg::P_AEN];

  // ==========================================================
  // pc personality decode
  assign port_idx = {pins.sync[uhp_pkg::P_PSC], // RULE23
                     pins.sync[uhp_pkg::P_PSB], // RULE23
                     pins.sync[uhp_pkg::P_PSA]}; // RULE20

  assign port_entry = PORT_MAP[port_idx]; // RULE25

  logic com_hit;
  logic lpt1_hit;
  logic lpt2_hit;

  assign com_hit  = ~aen_low_s & port_entry[uhp_pkg::ADDR_W] // RULE16
                    & (host_addr[9:3] == port_entry[9:3]);
  assign lpt1_hit = ~aen_low_s & (host_addr[9:3] == uhp_pkg::LPT1_BASE[9:3]);
  assign lpt2_hit = ~aen_low_s & (host_addr[9:3] == uhp_pkg::LPT2_BASE[9:3]);

  // ==========================================================
  // standalone select latch
  // tracking while the strobe is low, holding while high; a host that
  // ties the strobe low gets a plain follower
  logic [2:0] lat_cs;
  logic [2:0] lat_a;

  always_ff @(posedge clk) begin
    if (rst) begin
      lat_cs <= uhp_pkg::CS_RST;
      lat_a  <= uhp_pkg::ADDR_RST;
    end else if (!aen_low_s) begin // RULE17 RULE18
      lat_cs <= {pins.sync[uhp_pkg::P_A7], pins.sync[uhp_pkg::P_A6], pins.sync[uhp_pkg::P_A5]};
      lat_a  <= pins.sync[uhp_pkg::P_A0 +: 3];
    end
  end

  logic std_sel;

  assign std_sel = lat_cs[0] & lat_cs[1] & ~lat_cs[2]; // RULE2 RULE22

  // ==========================================================
  // access qualification
  logic selected;
  logic wr_strobe;
  logic rd_strobe;
  logic wr_act;
  logic rd_act;

  assign selected  = pc ? com_hit : std_sel;
  // in pc personality the high strobes are address lines and never write
  assign wr_strobe = ~pins.sync[uhp_pkg::P_IOW]
                     | (~pc & pins.sync[uhp_pkg::P_A8]); // RULE8
  assign rd_strobe = ~pins.sync[uhp_pkg::P_IOR]
                     | (~pc & pins.sync[uhp_pkg::P_A3]); // RULE11
  assign wr_act    = wr_strobe & selected;
  assign rd_act    = rd_strobe & selected & ~wr_act;

  logic wr_q;
  logic rd_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q <= uhp_pkg::LOW_RST;
      rd_q <= uhp_pkg::LOW_RST;
    end else begin
      wr_q <= wr_act;
      rd_q <= rd_act;
    end
  end

  // ==========================================================
  // register access toward the core
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_addr <= uhp_pkg::ADDR_RST;
    end else begin
      reg_addr <= pc ? host_addr[2:0] : lat_a; // RULE19
    end
  end

  // one write per strobe; data taken as the strobe is first seen
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_wr    <= uhp_pkg::LOW_RST;
      reg_wdata <= uhp_pkg::DATA_RST;
    end else begin
      reg_wr <= wr_act & ~wr_q; // RULE6 RULE8
      if (wr_act && !wr_q) begin
        reg_wdata <= bus_s; // RULE6
      end
    end
  end

  // the pop pulse lets the core advance a fifo once per read
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rd       <= uhp_pkg::LOW_RST;
      pin_data_oe  <= uhp_pkg::LOW_RST;
      pin_data_out <= uhp_pkg::DATA_RST;
    end else begin
      reg_rd       <= rd_act & ~rd_q;
      pin_data_oe  <= rd_act; // RULE9 RULE11
      pin_data_out <= rd_act ? reg_rdata : uhp_pkg::DATA_RST; // RULE9
    end
  end

  // ==========================================================
  // 16x baud clock
  // divisors below two cannot form a square wave and hold the clock low
  logic [uhp_pkg::BAUD_DIV_W-1:0] baud_cnt;
  logic                           baud_int;

  always_ff @(posedge clk) begin
    if (rst) begin
      baud_cnt <= uhp_pkg::BAUD_CNT_RST;
    end else if (baud_cnt >= baud_divisor - 16'h0001) begin
      baud_cnt <= uhp_pkg::BAUD_CNT_RST;
    end else begin
      baud_cnt <= baud_cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      baud_int <= uhp_pkg::LOW_RST;
    end else begin
      baud_int <= (baud_divisor > 16'h0001) && (baud_cnt < (baud_divisor >> 1)); // RULE3
    end
  end

  // receiver clock: internal in pc, looped back through the pin otherwise
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_clk <= uhp_pkg::LOW_RST;
    end else begin
      rx_clk <= pc ? baud_int : pins.sync[uhp_pkg::P_RCLK]; // RULE4
    end
  end

  // ==========================================================
  // dual function outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      baud_clk_or_printer1_decode      <= uhp_pkg::HIGH_RST;
      drive_disable_or_printer2_decode <= uhp_pkg::HIGH_RST;
      pc_decode_personality            <= uhp_pkg::LOW_RST;
    end else begin
      baud_clk_or_printer1_decode      <= pc ? ~lpt1_hit : baud_int; // RULE5 RULE3
      drive_disable_or_printer2_decode <= pc ? ~lpt2_hit : ~rd_act; // RULE13 RULE12
      pc_decode_personality            <= pc;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_c_or_tx_fifo_full        <= uhp_pkg::LOW_RST;
      irq_c_or_tx_fifo_full_oe     <= uhp_pkg::LOW_RST;
      irq_b_or_rx_fifo_full_low    <= uhp_pkg::HIGH_RST;
      irq_b_or_rx_fifo_full_low_oe <= uhp_pkg::LOW_RST;
    end else begin
      irq_c_or_tx_fifo_full        <= pc ? irq_c : tx_fifo_full; // RULE14
      irq_c_or_tx_fifo_full_oe     <= pc ? irq_drive_en : uhp_pkg::HIGH_RST; // RULE14
      irq_b_or_rx_fifo_full_low    <= pc ? irq_b : ~rx_fifo_full; // RULE15
      irq_b_or_rx_fifo_full_low_oe <= pc ? irq_drive_en : uhp_pkg::HIGH_RST; // RULE15
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_WR_ONCE: assert property ($rose(wr_act) |=> reg_wr ##1 !reg_wr) // RULE6
    else $error("write strobe did not give a single write pulse");

  AST_WR_DATA: assert property ($rose(wr_act) |=> reg_wdata == $past(bus_s)) // RULE6
    else $error("write data not taken from the host bus");

  AST_WR_HIGH: assert property (!pc && selected && pins.sync[uhp_pkg::P_A8]
                                && pins.sync[uhp_pkg::P_IOW] && !wr_q
                                |=> reg_wr) // RULE8
    else $error("high write strobe alone did not write");

  AST_RD_DRIVE: assert property (rd_act |=> pin_data_oe && pin_data_out == $past(reg_rdata)) // RULE9
    else $error("read did not drive the register contents");

  AST_RD_ONCE: assert property ($rose(rd_act) |=> reg_rd ##1 !reg_rd) // RULE9
    else $error("read strobe did not give a single pop pulse");

  AST_RD_HIGH: assert property (!pc && selected && pins.sync[uhp_pkg::P_A3]
                                && pins.sync[uhp_pkg::P_IOR] && !wr_act
                                |=> pin_data_oe) // RULE11
    else $error("high read strobe alone did not read");

  AST_DDIS: assert property (!pc && rd_act |=> !drive_disable_or_printer2_decode) // RULE12
    else $error("drive disable not low during standalone read");

  AST_LPT1: assert property (pc && lpt1_hit |=> !baud_clk_or_printer1_decode) // RULE5
    else $error("first printer decode missing");

  AST_LPT2: assert property (pc && !lpt2_hit |=> drive_disable_or_printer2_decode) // RULE13
    else $error("second printer decode asserted without a hit");

  AST_TXRDY: assert property (!pc |=> irq_c_or_tx_fifo_full_oe
                              && irq_c_or_tx_fifo_full == $past(tx_fifo_full)) // RULE14
    else $error("tx fifo full not shown in standalone");

  AST_RXRDY: assert property (!pc |=> irq_b_or_rx_fifo_full_low_oe
                              && irq_b_or_rx_fifo_full_low == !$past(rx_fifo_full)) // RULE15
    else $error("rx fifo full not shown low in standalone");

  AST_AEN: assert property (pc && aen_low_s |=> !pin_data_oe && !reg_wr) // RULE16
    else $error("access taken with address enable high");

  AST_STD_SEL: assert property (!pc && !std_sel |=> !pin_data_oe) // RULE22
    else $error("standalone read without full chip select");

  AST_HOLD: assert property (!pc && aen_low_s ##1 aen_low_s |-> $stable(lat_a)) // RULE17
    else $error("latched address moved while strobe high");

  AST_RXCLK: assert property (pc |=> rx_clk == $past(baud_int)) // RULE4
    else $error("receiver clock not fed from baud clock");

  COV_PC_WRITE: cover property (pc && com_hit ##1 reg_wr);
  COV_STD_READ: cover property (!pc && std_sel && rd_act ##1 pin_data_oe);
  COV_BAUD:     cover property (!pc && $rose(baud_clk_or_printer1_decode));
  COV_PC_READ:  cover property (pc && com_hit && rd_act ##1 pin_data_oe);
  COV_LATCHED:  cover property (!pc && aen_low_s && std_sel ##1 reg_wr);

endmodule

// file: core/uhp_sync.sv
// two flip-flop resynchroniser for the asynchronous host pins
`timescale 1ns/10ps
module uhp_sync (
  input  wire logic   clk,
  input  wire logic   rst,
  uhp_pin_if.sampler  pins
);

  logic [uhp_pkg::PIN_W-1:0] meta;

  // the first stage feeds the second only
  always_ff @(posedge clk) begin
    if (rst) begin
      meta      <= uhp_pkg::PIN_IDLE;
      pins.sync <= uhp_pkg::PIN_IDLE;
    end else begin
      meta      <= pins.raw;
      pins.sync <= meta;
    end
  end

endmodule

// file: inc/uhp_pin_if.sv
// raw and resynchronised pin levels passed between the port and its sampler
`timescale 1ns/10ps
interface uhp_pin_if;
  logic [uhp_pkg::PIN_W-1:0] raw;
  logic [uhp_pkg::PIN_W-1:0] sync;
  modport sampler (input raw, output sync);
  modport user    (output raw, input sync);
endinterface

// file: inc/uhp_pkg.sv
// constants shared by the host bus port and its pin sampler
package uhp_pkg;

  // ==========================================================
  // sampled pin vector layout
  localparam int PIN_W  = 26;
  localparam int P_DATA = 0;
  localparam int P_A0   = 8;
  localparam int P_A3   = 11;
  localparam int P_A4   = 12;
  localparam int P_A5   = 13;
  localparam int P_A6   = 14;
  localparam int P_A7   = 15;
  localparam int P_A8   = 16;
  localparam int P_A9   = 17;
  localparam int P_SEL  = 18;
  localparam int P_IOW  = 19;
  localparam int P_IOR  = 20;
  localparam int P_AEN  = 21;
  localparam int P_PSA  = 22;
  localparam int P_PSB  = 23;
  localparam int P_PSC  = 24;
  localparam int P_RCLK = 25;

  // idle level of the sampled pins: strobes, enables and select high
  localparam logic [PIN_W-1:0] PIN_IDLE = 26'h03C_0000;

  // ==========================================================
  // address decode
  localparam int ADDR_W = 10;
  localparam int SEL_W  = 3;
  localparam logic [ADDR_W-1:0] LPT1_BASE = 10'h378;
  localparam logic [ADDR_W-1:0] LPT2_BASE = 10'h278;

  // one port map entry: valid bit above a ten bit base address
  typedef logic [ADDR_W:0] uhp_port_t;

  // indexed by {port_select_c, port_select_b, port_select_a}
  localparam uhp_port_t [7:0] COM_MAP_DEF = {
    11'h000, 11'h000, 11'h000, 11'h000,
    11'h6E8, 11'h7E8, 11'h6F8, 11'h7F8
  };

  // ==========================================================
  // baud generator
  localparam int BAUD_DIV_W = 16;
  localparam logic [BAUD_DIV_W-1:0] BAUD_CNT_RST = 16'h0000;

  // ==========================================================
  // reset values
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [2:0] ADDR_RST = 3'h0;
  localparam logic       HIGH_RST = 1'h1;
  localparam logic       LOW_RST  = 1'h0;
  localparam logic [2:0] CS_RST   = 3'h4;

endpackage

// file: verif/uhp_host_model.sv
// host bus model: drives the dual-function host pins of the port
`timescale 1ns/10ps
module uhp_host_model (
  input  wire logic       clk,
  input  wire logic       baud_in,
  output logic      [7:0] data,
  output logic      [9:0] addr,
  output logic            wr_n,
  output logic            rd_n,
  output logic            as_n,
  output logic            sel_a,
  output wire logic       sel_b,
  output logic            sel_c,
  output logic            pers
);
  logic sel_b_q;
  // board loop from the baud pin back into the receive clock pin
  assign sel_b = pers ? baud_in : sel_b_q;
  initial begin
    data = 8'h00;
    addr = 10'h000;
    wr_n = 1'b1;
    rd_n = 1'b1;
    as_n = 1'b1;
    {sel_c, sel_b_q, sel_a} = 3'h0;
    pers = 1'b1;
  end
  // ==========================================================
  // bus cycles
  task automatic strap(input logic [2:0] s);
    @(posedge clk);
    {sel_c, sel_b_q, sel_a} <= s;
  endtask
  // address, data and address strobe settle well ahead of a strobe
  task automatic setup(input logic pc, input logic [9:0] a, input logic [7:0] d,
                       input logic asn);
    @(posedge clk);
    pers <= ~pc;
    addr <= a;
    data <= d;
    as_n <= asn;
    repeat (4) @(posedge clk);
  endtask
  task automatic strobe_on(input int kind);
    @(posedge clk);
    case (kind)
      0: wr_n <= 1'b0;
      1: addr[8] <= 1'b1;
      2: rd_n <= 1'b0;
      default: addr[3] <= 1'b1;
    endcase
  endtask
  task automatic strobe_off();
    @(posedge clk);
    wr_n <= 1'b1;
    rd_n <= 1'b1;
    if (pers) begin
      addr[8] <= 1'b0;
      addr[3] <= 1'b0;
    end
    // a released bus does not keep its last level
    data <= ~data;
    repeat (4) @(posedge clk);
  endtask
endmodule

// file: verif/uhp_host_port_tb.sv
// self-checking bench for the host bus port
`timescale 1ns/10ps
module uhp_host_port_tb;
  logic        clk;
  logic        rst;
  logic [7:0]  data_out, h_data, wdata, wd, rdata;
  logic        data_oe, baud, ddis, irqc, irqc_oe, irqb, irqb_oe;
  logic [15:0] div;
  logic        irq_b_i, irq_c_i, irq_en, txf, rxf;
  logic [2:0]  ra, wa;
  logic        wr, rd, rx_clk, pc_mode;
  logic [9:0]  h_addr;
  logic        h_wr_n, h_rd_n, h_as_n, h_sa, h_sb, h_sc, h_pers;
  int          n_errors, cmp_count, wr_cnt, rd_cnt;
  logic [9:0]  com_base [4] = '{10'h3F8, 10'h2F8, 10'h3E8, 10'h2E8};
  logic [2:0]  desel [3] = '{3'b111, 3'b001, 3'b010};
  wire logic   bclk = h_pers ? baud : rx_clk;

  // register file stand-in: data depends on the selected index
  assign rdata = {5'h1A, ra};
  always #12.5 clk = ~clk;

  uhp_host_model host_u (
    .clk(clk), .baud_in(baud), .data(h_data), .addr(h_addr), .wr_n(h_wr_n),
    .rd_n(h_rd_n), .as_n(h_as_n), .sel_a(h_sa), .sel_b(h_sb), .sel_c(h_sc), .pers(h_pers)
  );
  uhp_host_port dut_u (
    .clk(clk), .rst(rst), .pin_data_in(h_data), .pin_data_out(data_out),
    .pin_data_oe(data_oe), .addr_low(h_addr[2:0]), .addr3_or_read_strobe_high(h_addr[3]),
    .addr4(h_addr[4]), .addr5_or_select_high_a(h_addr[5]),
    .addr6_or_select_high_b(h_addr[6]), .addr7_or_select_low(h_addr[7]),
    .addr8_or_write_strobe_high(h_addr[8]), .addr9(h_addr[9]),
    .write_strobe_low(h_wr_n), .read_strobe_low(h_rd_n),
    .addr_enable_or_addr_latch_low(h_as_n), .port_select_a(h_sa),
    .port_select_b_or_rx_clk(h_sb), .port_select_c(h_sc), .personality_sel(h_pers),
    .baud_clk_or_printer1_decode(baud), .drive_disable_or_printer2_decode(ddis),
    .irq_c_or_tx_fifo_full(irqc), .irq_c_or_tx_fifo_full_oe(irqc_oe),
    .irq_b_or_rx_fifo_full_low(irqb), .irq_b_or_rx_fifo_full_low_oe(irqb_oe),
    .baud_divisor(div), .irq_b(irq_b_i), .irq_c(irq_c_i), .irq_drive_en(irq_en),
    .tx_fifo_full(txf), .rx_fifo_full(rxf), .reg_rdata(rdata), .reg_addr(ra),
    .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .rx_clk(rx_clk),
    .pc_decode_personality(pc_mode)
  );

  // ==========================================================
  // monitor and checks
  always @(posedge clk) begin
    if (wr === 1'b1) begin
      wr_cnt++;
      wd = wdata;
      wa = ra;
    end
    if (rd === 1'b1) rd_cnt++;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  function automatic logic [9:0] sa(input logic [2:0] c, input logic [2:0] n);
    return {2'b00, c, 2'b00, n};
  endfunction
  // one access; hit says whether the register side must see it
  task automatic access(input logic pc, input logic [9:0] a, input int kind,
                        input logic asn, input logic hit, input logic [7:0] d);
    int w0;
    int r0;
    w0 = wr_cnt;
    r0 = rd_cnt;
    host_u.setup(pc, a, d, asn);
    host_u.strobe_on(kind);
    // strobes pass a resynchroniser, so effects lag the pins
    repeat (6) @(posedge clk);
    #1;
    if (kind < 2) begin
      chk(16'(wr_cnt - w0), hit, "write count");
      if (hit) chk({wa, wd}, {a[2:0], d}, "write reg");
    end else begin
      chk(16'(rd_cnt - r0), hit, "read count");
      chk({data_oe, data_out}, {hit, hit ? {5'h1A, a[2:0]} : 8'h00}, "read bus");
      if (!pc) chk(ddis, !hit, "drive disable");
    end
    host_u.strobe_off();
    #1;
    chk({data_oe, ddis}, 2'b01, "released");
  endtask

  // ==========================================================
  // scenarios
  task automatic t_pc_map();
    for (int s = 0; s < 4; s++) begin
      host_u.strap(s[2:0]);
      access(1'b1, com_base[s] + 10'(s + 3), 0, 1'b0, 1'b1, 8'hA0 + 8'(s));
    end
    host_u.strap(3'h4);
    access(1'b1, 10'h3F9, 0, 1'b0, 1'b0, 8'h12);
    host_u.strap(3'h0);
    for (int b = 3; b < 10; b++) begin
      access(1'b1, 10'h3F9 ^ (10'h001 << b), 0, 1'b0, 1'b0, 8'h55);
    end
    access(1'b1, 10'h3F9, 0, 1'b1, 1'b0, 8'h66);
    access(1'b1, 10'h3FD, 2, 1'b0, 1'b1, 8'h00);
    $display("pc decode test done");
  endtask
  task automatic t_printer();
    host_u.setup(1'b1, 10'h378, 8'h00, 1'b0);
    #1;
    chk({baud, ddis}, 2'b01, "lpt1");
    host_u.setup(1'b1, 10'h278, 8'h00, 1'b0);
    #1;
    chk({baud, ddis}, 2'b10, "lpt2");
    host_u.setup(1'b1, 10'h278, 8'h00, 1'b1);
    #1;
    chk({baud, ddis}, 2'b11, "no enable");
    $display("printer test done");
  endtask
  task automatic t_baud(input logic pc);
    int per;
    int hi;
    logic p;
    host_u.setup(pc, 10'h000, 8'h00, 1'b1);
    per = 0;
    hi = 0;
    p = 1'b1;
    for (int i = 0; i < 30 && !(p === 1'b0 && bclk === 1'b1); i++) begin
      p = bclk;
      @(posedge clk);
      #1;
    end
    do begin
      hi += (bclk === 1'b1);
      p = bclk;
      @(posedge clk);
      #1;
      per++;
    end while (per < 40 && !(p === 1'b0 && bclk === 1'b1));
    chk(16'(per), 16'h000A, "period");
    chk(16'(hi), 16'h0005, "high time");
    if (pc) chk(baud, 1'b1, "baud pin in pc");
    $display("baud test done");
  endtask
  task automatic t_sa();
    for (int k = 0; k < 4; k++) begin
      access(1'b0, sa(3'b011, 3'(k + 1)), k, 1'b0, 1'b1, 8'h3C ^ 8'(k));
    end
    foreach (desel[i]) access(1'b0, sa(desel[i], 3'd2), 0, 1'b0, 1'b0, 8'h11);
    $display("standalone test done");
  endtask
  task automatic t_latch();
    int w0;
    host_u.setup(1'b0, sa(3'b011, 3'd6), 8'h6C, 1'b0);
    host_u.setup(1'b0, sa(3'b011, 3'd6), 8'h6C, 1'b1);
    host_u.setup(1'b0, sa(3'b110, 3'd1), 8'h6C, 1'b1);
    w0 = wr_cnt;
    host_u.strobe_on(0);
    repeat (6) @(posedge clk);
    #1;
    chk(16'(wr_cnt - w0), 16'h0001, "latched write");
    chk({wa, wd}, {3'd6, 8'h6C}, "latched reg");
    host_u.strobe_off();
    $display("latch test done");
  endtask
  task automatic t_irq();
    host_u.setup(1'b1, 10'h000, 8'h00, 1'b1);
    irq_en <= 1'b1;
    irq_c_i <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({pc_mode, irqc, irqc_oe, irqb, irqb_oe}, 5'b11101, "pc irq");
    irq_en <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk({irqc_oe, irqb_oe}, 2'b00, "irq off");
    host_u.setup(1'b0, 10'h000, 8'h00, 1'b1);
    txf <= 1'b1;
    rxf <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({pc_mode, irqc, irqc_oe, irqb, irqb_oe}, 5'b01101, "fifo full");
    txf <= 1'b0;
    rxf <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk({irqc, irqb}, 2'b01, "fifo free");
    $display("irq test done");
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    div = 16'h000A;
    {irq_b_i, irq_c_i, irq_en, txf, rxf} = 5'h00;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({data_oe, baud, ddis, irqc_oe, pc_mode}, 5'b01100, "reset");
    t_pc_map();
    t_printer();
    t_baud(1'b1);
    t_baud(1'b0);
    t_sa();
    t_latch();
    t_irq();
    finish_test();
  end
  initial begin
    #200000;
    n_errors++;
    $display("wrong value at %0t: watchdog", $time);
    finish_test();
  end
endmodule
